// ==== design/tmw_timer8.sv ====
// 8-bit timer/counter with two compare channels and waveform outputs.
// Assumes an APB master on mclk and external tick pin synchronous to mclk.
`timescale 1ns/100ps
module tmw_timer8
  import tmw_pkg::*;
(
  input  wire logic        mclk,         // System clock, 10 MHz
  input  wire logic        rst,          // Synchronous reset, active high
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        extTick,      // External count input
  input  wire logic        ovfIntAck,    // Overflow interrupt executed
  input  wire logic        cmpAIntAck,   // Compare A interrupt executed
  input  wire logic        cmpBIntAck,   // Compare B interrupt executed
  output logic             overflowReq,  // Overflow flag level
  output logic             compareAReq,  // Compare A flag level
  output logic             compareBReq,  // Compare B flag level
  output logic             waveOutA,     // Compare output A
  output logic             waveOutB,     // Compare output B
  output logic             waveOeA,      // Pin A driven
  output logic             waveOeB       // Pin B driven
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrlA_r;
  logic [7:0]  ctrlB_r;
  logic [7:0]  counterValue_r;
  logic [7:0]  compareRegA_r, compareRegB_r;   // Active copies
  logic [7:0]  bufA_r, bufB_r;                 // Software-written copies
  logic        ovfFlag_r, cmpFlagA_r, cmpFlagB_r;
  logic        countDown_r;
  logic        outA_r, outB_r;
  tmw_com_type com_r;                          // Mode latched at last match, or at last force outside PWM modes
  logic [9:0]  prescale_r;
  logic        extPrev_r;

  logic        wrEn, rdEn, addrOk;
  logic        tick;
  logic [2:0]  clockSelectField;
  tmw_mode_type mode;
  logic [7:0]  topVal;
  logic        isPwm, isPc, isFast;
  logic        atBottom, atMax, atTop;
  logic        matchA, matchB;
  logic        forceA, forceB;
  logic        cntWr;

  assign clockSelectField = ctrlB_r[2:0];
  assign mode = tmw_mode_type'({ctrlB_r[TMW_B_WGM_MSB], ctrlA_r[1:0]});
  assign isPc   = (mode == TMW_PC_FF) || (mode == TMW_PC_A);
  assign isFast = (mode == TMW_FAST_FF) || (mode == TMW_FAST_A);
  assign isPwm  = isPc || isFast;
  assign topVal = (mode == TMW_CTC || mode == TMW_PC_A ||
                   mode == TMW_FAST_A) ? compareRegA_r : TMW_MAX;
  assign atBottom = (counterValue_r == TMW_BOTTOM);
  assign atMax    = (counterValue_r == TMW_MAX);
  assign atTop    = (counterValue_r == topVal);
  assign matchA   = (counterValue_r == compareRegA_r);
  assign matchB   = (counterValue_r == compareRegB_r);

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states
  assign pready = 1'b1;
  always_comb
  begin
    addrOk = 1'b1;
    case (paddr)
      TMW_OFS_CTRLA, TMW_OFS_CTRLB, TMW_OFS_COUNT, TMW_OFS_CMPA,
      TMW_OFS_CMPB, TMW_OFS_FLAGS, TMW_OFS_ACK: addrOk = 1'b1;
      default: addrOk = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addrOk;
  assign wrEn = psel && penable && pwrite && addrOk;
  assign rdEn = psel && !penable && !pwrite;
  assign cntWr = wrEn && (paddr == TMW_OFS_COUNT);
  assign forceA = wrEn && (paddr == TMW_OFS_CTRLB) && pwdata[TMW_B_FORCE_A];
  assign forceB = wrEn && (paddr == TMW_OFS_CTRLB) && pwdata[TMW_B_FORCE_B];

  always_ff @(posedge mclk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (rdEn)
    begin
      case (paddr)
        TMW_OFS_CTRLA: prdata <= {24'h00_0000, ctrlA_r[7:4], 2'h0,
                                  ctrlA_r[1:0]};
        TMW_OFS_CTRLB: prdata <= {24'h00_0000, 2'h0, ctrlB_r[5:0]};
        TMW_OFS_COUNT: prdata <= {24'h00_0000, counterValue_r};
        TMW_OFS_CMPA:  prdata <= {24'h00_0000, bufA_r};
        TMW_OFS_CMPB:  prdata <= {24'h00_0000, bufB_r};
        TMW_OFS_FLAGS: prdata <= {29'h0000_0000, cmpFlagB_r, cmpFlagA_r,
                                  ovfFlag_r};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrlA_r <= TMW_CTRL_RESET;
      ctrlB_r <= TMW_CTRL_RESET;
      bufA_r  <= TMW_BOTTOM;
      bufB_r  <= TMW_BOTTOM;
    end
    else if (wrEn)
    begin
      case (paddr)
        TMW_OFS_CTRLA: ctrlA_r <= {pwdata[7:4], 2'h0, pwdata[1:0]};
        // Force bits are strobes, never stored
        TMW_OFS_CTRLB: ctrlB_r <= {2'h0, pwdata[5:0]};
        TMW_OFS_CMPA:  bufA_r  <= pwdata[7:0];
        TMW_OFS_CMPB:  bufB_r  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick select: prescaler runs free; edge modes watch the pin
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prescale_r <= TMW_PS_RESET;
      extPrev_r  <= 1'b0;
    end
    else
    begin
      prescale_r <= prescale_r + 10'h001;
      extPrev_r  <= extTick;
    end
  end

  always_comb
  begin
    case (clockSelectField)
      TMW_CS_NONE:   tick = 1'b0;
      TMW_CS_DIV1:   tick = 1'b1;
      TMW_CS_DIV8:   tick = (prescale_r[2:0] == 3'h7);
      TMW_CS_DIV64:  tick = (prescale_r[5:0] == 6'h3f);
      TMW_CS_DIV256: tick = (prescale_r[7:0] == 8'hff);
      TMW_CS_DIV1K:  tick = (prescale_r == 10'h3ff);
      TMW_CS_EXTF:   tick = extPrev_r && !extTick;
      TMW_CS_EXTR:   tick = !extPrev_r && extTick;
      default:       tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; sequence depends on waveform mode and on compare A in modes where it is TOP
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      counterValue_r <= TMW_BOTTOM;
      countDown_r    <= 1'b0;
    end
    else if (cntWr)
      counterValue_r <= pwdata[7:0];
    else if (tick)
    begin
      case (mode)
        TMW_PC_FF, TMW_PC_A:
        begin
          if (!countDown_r && atTop)
          begin
            countDown_r    <= 1'b1;
            counterValue_r <= counterValue_r - 8'h01;
          end
          else if (countDown_r && atBottom)
          begin
            countDown_r    <= 1'b0;
            counterValue_r <= counterValue_r + 8'h01;
          end
          else if (countDown_r)
            counterValue_r <= counterValue_r - 8'h01;
          else
            counterValue_r <= counterValue_r + 8'h01;
        end
        TMW_CTC, TMW_FAST_FF, TMW_FAST_A:
        begin
          countDown_r    <= 1'b0;
          counterValue_r <= atTop ? TMW_BOTTOM
                                  : counterValue_r + 8'h01;
        end
        default:
        begin
          countDown_r    <= 1'b0;
          counterValue_r <= counterValue_r + 8'h01;
        end
      endcase
    end
  end

  // Double buffering of compare registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      compareRegA_r <= TMW_BOTTOM;
      compareRegB_r <= TMW_BOTTOM;
    end
    else if (!isPwm || (tick && atTop))
    begin
      compareRegA_r <= bufA_r;
      compareRegB_r <= bufB_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over acknowledge
  logic ovfEvent;
  always_comb
  begin
    case (mode)
      TMW_PC_FF, TMW_PC_A: ovfEvent = atBottom && countDown_r;
      TMW_FAST_A:          ovfEvent = atTop;
      TMW_FAST_FF:         ovfEvent = atMax;
      default:             ovfEvent = atMax;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ovfFlag_r  <= 1'b0;
      cmpFlagA_r <= 1'b0;
      cmpFlagB_r <= 1'b0;
    end
    else
    begin
      // Set with the tick that brings the counter to zero in normal mode
      if (tick && ovfEvent)
        ovfFlag_r <= 1'b1;
      else if (ovfIntAck)
        ovfFlag_r <= 1'b0;
      if (tick && matchA)
        cmpFlagA_r <= 1'b1;
      else if (cmpAIntAck ||
               (wrEn && paddr == TMW_OFS_ACK && pwdata[TMW_F_CMPA]))
        cmpFlagA_r <= 1'b0;
      if (tick && matchB)
        cmpFlagB_r <= 1'b1;
      else if (cmpBIntAck ||
               (wrEn && paddr == TMW_OFS_ACK && pwdata[TMW_F_CMPB]))
        cmpFlagB_r <= 1'b0;
    end
  end
  assign overflowReq = ovfFlag_r;
  assign compareAReq = cmpFlagA_r;
  assign compareBReq = cmpFlagB_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output action: new mode latched at a match, or at a force outside PWM modes
  function automatic logic waveNext(input logic cur, input logic [1:0] cm,
                                    input logic pwm, input logic pc,
                                    input logic down, input logic bot);
    logic v;
    v = cur;
    if (cm == 2'h0 || cm == 2'h1 && pwm)
      v = cur;
    else if (pc)
      v = (cm == 2'h3) ^ down;
    else if (pwm)
      v = (cm == 2'h2) ? bot : !bot;
    else
      case (cm)
        2'h1:    v = !cur;
        2'h2:    v = 1'b0;
        default: v = 1'b1;
      endcase
    return v;
  endfunction : waveNext

  logic [1:0] comANew, comBNew;
  logic       hitA, hitB, bTop;
  assign comANew = ctrlA_r[TMW_A_COMA_HI:TMW_A_COMA_LO];
  assign comBNew = ctrlA_r[TMW_A_COMB_HI:TMW_A_COMB_LO];
  // Phase-correct with comBNew[1] set and B equal to TOP: match ignored, action taken at TOP instead
  assign bTop = isPc && comBNew[1] && (compareRegB_r == topVal);
  assign hitA = tick && matchA;
  assign hitB = tick && (bTop ? atTop && !countDown_r : matchB);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      com_r  <= '0;
      outA_r <= 1'b0;
      outB_r <= 1'b0;
    end
    else
    begin
      if (hitA || (forceA && !isPwm))
      begin
        com_r.comA <= comANew;
        outA_r <= waveNext(outA_r, comANew, isPwm, isPc, countDown_r,
                           1'b0);
      end
      else if (isFast && tick && atTop && com_r.comA[1])
        outA_r <= waveNext(outA_r, com_r.comA, 1'b1, 1'b0, 1'b0, 1'b1);
      if (hitB || (forceB && !isPwm))
      begin
        com_r.comB <= comBNew;
        outB_r <= waveNext(outB_r, comBNew, isPwm, isPc,
                           bTop ? 1'b0 : countDown_r, 1'b0);
      end
      else if (isFast && tick && atTop && com_r.comB[1])
        outB_r <= waveNext(outB_r, com_r.comB, 1'b1, 1'b0, 1'b0, 1'b1);
    end
  end

  assign waveOutA = outA_r;
  assign waveOutB = outB_r;
  assign waveOeA  = (com_r.comA != 2'h0);
  assign waveOeB  = (com_r.comB != 2'h0);

endmodule : tmw_timer8

// ==== include/tmw_pkg.sv ====
// Package for the 8-bit timer/waveform unit: register map, fields, modes.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
package tmw_pkg;
  localparam logic [7:0] TMW_OFS_CTRLA  = 8'h00;
  localparam logic [7:0] TMW_OFS_CTRLB  = 8'h04;
  localparam logic [7:0] TMW_OFS_COUNT  = 8'h08;
  localparam logic [7:0] TMW_OFS_CMPA   = 8'h0c;
  localparam logic [7:0] TMW_OFS_CMPB   = 8'h10;
  localparam logic [7:0] TMW_OFS_FLAGS  = 8'h14;
  localparam logic [7:0] TMW_OFS_ACK    = 8'h18;
  localparam logic [7:0] TMW_BOTTOM     = 8'h00;
  localparam logic [7:0] TMW_MAX        = 8'hff;
  localparam logic [7:0] TMW_CTRL_RESET = 8'h00;
  // Control A fields
  localparam int TMW_A_COMA_HI = 7;
  localparam int TMW_A_COMA_LO = 6;
  localparam int TMW_A_COMB_HI = 5;
  localparam int TMW_A_COMB_LO = 4;
  // Control B fields
  localparam int TMW_B_FORCE_A = 7;
  localparam int TMW_B_FORCE_B = 6;
  localparam int TMW_B_WGM_MSB = 3;
  // Flag bits
  localparam int TMW_F_OVF  = 0;
  localparam int TMW_F_CMPA = 1;
  localparam int TMW_F_CMPB = 2;
  // Clock select codes
  localparam logic [2:0] TMW_CS_NONE   = 3'h0;
  localparam logic [2:0] TMW_CS_DIV1   = 3'h1;
  localparam logic [2:0] TMW_CS_DIV8   = 3'h2;
  localparam logic [2:0] TMW_CS_DIV64  = 3'h3;
  localparam logic [2:0] TMW_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMW_CS_DIV1K  = 3'h5;
  localparam logic [2:0] TMW_CS_EXTF   = 3'h6;
  localparam logic [2:0] TMW_CS_EXTR   = 3'h7;
  localparam logic [9:0] TMW_PS_RESET  = 10'h000;

  typedef enum logic [2:0] {
    TMW_NORMAL = 3'h0, TMW_PC_FF = 3'h1, TMW_CTC = 3'h2, TMW_FAST_FF = 3'h3,
    TMW_RSV4 = 3'h4, TMW_PC_A = 3'h5, TMW_RSV6 = 3'h6, TMW_FAST_A = 3'h7
  } tmw_mode_type;

  typedef struct packed {
    logic [1:0] comA;
    logic [1:0] comB;
  } tmw_com_type;
endpackage : tmw_pkg

// ==== verif/test_timer8_waveform_unit.sv ====
// Bench for the timer unit: APB master, register model, scenarios.
// Assumes pready answers in the access cycle; a timeout ends a hang.
`timescale 1ns/100ps
module test_timer8_waveform_unit
  import tmw_pkg::*;
;
  logic        mclk, rst, psel, penable, pwrite, extTick, ob;
  logic        ovfIntAck, cmpAIntAck, cmpBIntAck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  logic [31:0] seed = 32'h6f4ae0e2;
  wire  logic [31:0] prdata;
  wire  logic  pready, pslverr, overflowReq, compareAReq, compareBReq;
  wire  logic  waveOutA, waveOutB, waveOeA, waveOeB;
  int          errTotal, samplesChecked, cyc;
  int          mdl [int];

  tmw_timer8 u_tmw_timer8 (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .extTick, .ovfIntAck, .cmpAIntAck,
    .cmpBIntAck, .overflowReq, .compareAReq, .compareBReq, .waveOutA,
    .waveOutB, .waveOeA, .waveOeB);
////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : reportAndStop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Idle edge first, so back-to-back calls never reassign in one step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(negedge mclk);
    ob = waveOutB;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a] = d[7:0] & (a == TMW_OFS_CTRLA ? 8'hf3 :
             a == TMW_OFS_CTRLB ? 8'h0f : 8'hff);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    check(q, mdl.exists(a) ? 32'(mdl[a]) : 32'h0);
  endtask : rd

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      errTotal++;
      reportAndStop();
    end
  end

  initial
  begin
    logic [7:0] a;
    int         k;
    {rst, psel, penable, pwrite, extTick} = 5'h10;
    {ovfIntAck, cmpAIntAck, cmpBIntAck} = 3'h0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Reset values, last address is unmapped
    for (int i = 0; i < 8; i++)
      rd(8'(4 * i));
    wr(TMW_OFS_CTRLA, 32'hffffffff);
    rd(TMW_OFS_CTRLA);
    wr(TMW_OFS_CTRLB, 32'h000000c8);
    rd(TMW_OFS_CTRLB);
    wr(TMW_OFS_CTRLB, 32'h0);
    wr(TMW_OFS_CTRLA, 32'h0);
    repeat (6)
    begin
      a = TMW_OFS_COUNT + 8'(4 * (rnd() % 3));
      wr(a, rnd());
      repeat (rnd() % 16) @(posedge mclk);
      rd(a);
    end
    // Normal mode wrap near MAX
    wr(TMW_OFS_COUNT, 32'hfc);
    wr(TMW_OFS_CTRLB, 32'h1);
    for (int n = 0; n < 40 && overflowReq !== 1'b1; n++)
      @(posedge mclk);
    wr(TMW_OFS_CTRLB, 32'h0);
    check(overflowReq, 1'b1);
    apb(1'b0, TMW_OFS_COUNT, 32'h0);
    check(q < 32'h10, 1'b1);
    ovfIntAck <= 1'b1;
    @(posedge mclk);
    ovfIntAck <= 1'b0;
    @(posedge mclk);
    check(overflowReq, 1'b0);
    // Clear on match with compare A
    wr(TMW_OFS_CTRLA, 32'h2);
    wr(TMW_OFS_CMPA, 32'h5);
    wr(TMW_OFS_CMPB, 32'h3);
    wr(TMW_OFS_COUNT, 32'h0);
    wr(TMW_OFS_CTRLB, 32'h1);
    repeat (50) @(posedge mclk);
    wr(TMW_OFS_CTRLB, 32'h0);
    apb(1'b0, TMW_OFS_COUNT, 32'h0);
    check(q < 32'h6, 1'b1);
    check({overflowReq, compareAReq, compareBReq}, 3'h3);
    wr(TMW_OFS_ACK, 32'h2);
    cmpBIntAck <= 1'b1;
    @(posedge mclk);
    cmpBIntAck <= 1'b0;
    @(posedge mclk);
    check({compareAReq, compareBReq}, 2'h0);
    // Forced actions, mode zero last
    for (int i = 1; i < 5; i++)
    begin
      wr(TMW_OFS_CTRLA, 32'((i % 4) * 32'h50));
      wr(TMW_OFS_CTRLB, 32'hc0);
      @(posedge mclk);
      check({waveOeA, waveOeB}, (i % 4) ? 2'h3 : 2'h0);
      check({waveOutA, waveOutB}, (i == 2) ? 2'h0 : 2'h3);
    end
    // External pin ticks, falling then rising edge select
    wr(TMW_OFS_CTRLA, 32'h0);
    for (int s = 6; s < 8; s++)
    begin
      wr(TMW_OFS_COUNT, 32'h0);
      wr(TMW_OFS_CTRLB, 32'(s));
      k = int'(rnd() % 8) + 1;
      repeat (k)
      begin
        @(posedge mclk);
        extTick <= 1'b1;
        @(posedge mclk);
        extTick <= 1'b0;
      end
      @(posedge mclk);
      wr(TMW_OFS_CTRLB, 32'h0);
      apb(1'b0, TMW_OFS_COUNT, 32'h0);
      check(q, 32'(k));
    end
    // Phase-correct channel B, both polarities
    wr(TMW_OFS_CMPB, 32'h80);
    for (int c = 2; c < 4; c++)
    begin
      wr(TMW_OFS_CTRLA, 32'(c * 16 + 1));
      wr(TMW_OFS_CTRLB, 32'h1);
      repeat (520) @(posedge mclk);
      repeat (16)
      begin
        repeat (rnd() % 32) @(posedge mclk);
        apb(1'b0, TMW_OFS_COUNT, 32'h0);
        if (q > 32'h83 || q < 32'h7d)
          check(ob, (q < 32'h80) ^ (c == 3));
      end
      wr(TMW_OFS_CTRLB, 32'h0);
    end
    reportAndStop();
  end
endmodule : test_timer8_waveform_unit

// ==== verif/tmw_timer8_assertions.sv ====
// Checker: read-back, flag and output rules of the timer unit.
// Assumes it is bound onto tmw_timer8 and sees its ports only.
`timescale 1ns/100ps
module tmw_timer8_assertions
  import tmw_pkg::*;
(
  input wire logic        mclk,        // Clock
  input wire logic        rst,         // Reset
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB enable
  input wire logic        pwrite,      // APB write
  input wire logic [7:0]  paddr,       // APB address
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic [31:0] prdata,      // APB read data
  input wire logic        pslverr,     // APB error
  input wire logic        ovfIntAck,   // Overflow ack
  input wire logic        cmpAIntAck,  // Compare A ack
  input wire logic        cmpBIntAck,  // Compare B ack
  input wire logic        overflowReq, // Overflow flag
  input wire logic        compareAReq, // Compare A flag
  input wire logic        compareBReq, // Compare B flag
  input wire logic        waveOutA,    // Output A
  input wire logic        waveOutB,    // Output B
  input wire logic        waveOeA,     // Pin A driven
  input wire logic        waveOeB      // Pin B driven
);
////////////////////////////////////////////////////////////
  logic [2:0] csR;
  wire  logic wrAcc = psel && penable && pwrite;
  wire  logic ackA  = wrAcc && paddr == TMW_OFS_ACK && pwdata[TMW_F_CMPA];
  wire  logic ackB  = wrAcc && paddr == TMW_OFS_ACK && pwdata[TMW_F_CMPB];

  // Shadow of the clock select, overflow and compare A flags may only rise while it runs
  always_ff @(posedge mclk)
    if (rst)
      csR <= 3'h0;
    else if (wrAcc && paddr == TMW_OFS_CTRLB)
      csR <= pwdata[2:0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_read(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  chk_ctrla_reserved: assert property (
    s_read(TMW_OFS_CTRLA) |-> prdata[3:2] == 2'h0) else $error("rsv bits");
  chk_force_reads: assert property (
    s_read(TMW_OFS_CTRLB) |-> prdata[7:6] == 2'h0) else $error("strobe");
  chk_unmapped_err: assert property (
    psel && penable && !pwrite && paddr > TMW_OFS_ACK |-> pslverr
    && prdata == 32'h0) else $error("unmapped read");
  chk_ovf_clear: assert property (
    $fell(overflowReq) |-> $past(ovfIntAck)) else $error("ovf cleared");
  chk_cmpa_clear: assert property (
    $fell(compareAReq) |-> $past(cmpAIntAck) || $past(ackA))
    else $error("cmp a cleared");
  chk_cmpb_clear: assert property (
    $fell(compareBReq) |-> $past(cmpBIntAck) || $past(ackB))
    else $error("cmp b cleared");
  chk_ovf_tick: assert property (
    $rose(overflowReq) |-> $past(csR) != 3'h0) else $error("ovf no clk");
  chk_cmpa_tick: assert property (
    $rose(compareAReq) |-> $past(csR) != 3'h0) else $error("cmp no clk");
  chk_quiet_a: assert property (
    $changed(waveOutA) |-> waveOeA) else $error("out a moved");
  chk_quiet_b: assert property (
    $changed(waveOutB) |-> waveOeB) else $error("out b moved");
endmodule : tmw_timer8_assertions

bind tmw_timer8 tmw_timer8_assertions u_tmw_timer8_assertions (.mclk,
  .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
  .ovfIntAck, .cmpAIntAck, .cmpBIntAck, .overflowReq, .compareAReq,
  .compareBReq, .waveOutA, .waveOutB, .waveOeA, .waveOeB);
